// File: dxw_ports.sv
`timescale 1ns/1ns
// Distributor stream ports toward translation service and wake request block
module dxw_ports #(
    parameter bit STITCHED = 1'b0
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic xo_valid,
    output logic xo_ready,
    input wire logic [dxw_pkg::DXW_XDATA_W-1:0] xo_data,
    input wire logic [dxw_pkg::DXW_XKEEP_W-1:0] xo_keep,
    input wire logic [dxw_pkg::DXW_XTAG_W-1:0] xo_dest,
    input wire logic xo_last,
    input wire logic xo_pending,
    output logic xs_tvalid,
    input wire logic xs_tready,
    output logic [dxw_pkg::DXW_XDATA_W-1:0] xs_tdata,
    output logic [dxw_pkg::DXW_XKEEP_W-1:0] xs_tkeep,
    output logic [dxw_pkg::DXW_XTAG_W-1:0] xs_tdest,
    output logic xs_tlast,
    output logic xs_twakeup,
    input wire logic xs_credit,
    input wire logic xr_tvalid,
    output logic xr_tready,
    input wire logic [dxw_pkg::DXW_XDATA_W-1:0] xr_tdata,
    input wire logic [dxw_pkg::DXW_XKEEP_W-1:0] xr_tkeep,
    input wire logic [dxw_pkg::DXW_XTAG_W-1:0] xr_tsrc,
    input wire logic xr_tlast,
    input wire logic xr_twakeup,
    output logic xr_credit,
    output logic xi_valid,
    output logic [dxw_pkg::DXW_XDATA_W-1:0] xi_data,
    output logic [dxw_pkg::DXW_XKEEP_W-1:0] xi_keep,
    output logic [dxw_pkg::DXW_XTAG_W-1:0] xi_src,
    output logic xi_last,
    output logic xi_awake,
    input wire logic wo_valid,
    output logic wo_ready,
    input wire logic [dxw_pkg::DXW_WDATA_W-1:0] wo_data,
    input wire logic wo_last,
    input wire logic wo_pending,
    output logic ws_tvalid,
    input wire logic ws_tready,
    output logic [dxw_pkg::DXW_WDATA_W-1:0] ws_tdata,
    output logic ws_tlast,
    output logic ws_twakeup,
    input wire logic ws_credit
);
    import dxw_pkg::*;

    localparam int XSW = DXW_XKEEP_W + DXW_XTAG_W;
    logic [XSW-1:0] xs_side;
    logic xs_pend;
    logic ws_tvalid_i;
    logic [DXW_WDATA_W-1:0] ws_tdata_i;
    logic ws_tlast_i;
    logic ws_twakeup_i;
    logic xr_wake_s1;
    logic xr_wake_s2;

    // Outbound to translation service, keep and destination as sideband
    dxw_tx_port #(.DW(DXW_XDATA_W), .SW(XSW), .CRED_RST(DXW_XCRED_RST)) u_xs (
        .mclk(mclk),
        .resetn(resetn),
        .s_valid(xo_valid),
        .s_ready(xo_ready),
        .s_data(xo_data),
        .s_side({xo_keep, xo_dest}),
        .s_last(xo_last),
        .s_pending(xs_pend),
        .m_tvalid(xs_tvalid),
        .m_tready(xs_tready),
        .m_tdata(xs_tdata),
        .m_tside(xs_side),
        .m_tlast(xs_tlast),
        .m_twakeup(xs_twakeup),
        .m_credit(xs_credit),
        .credits()
    );
    assign xs_pend = xo_pending;
    assign xs_tkeep = xs_side[XSW-1:DXW_XTAG_W];
    assign xs_tdest = xs_side[DXW_XTAG_W-1:0];

    // Outbound to wake request block, 16-bit data
    dxw_tx_port #(.DW(DXW_WDATA_W), .SW(1), .CRED_RST(DXW_WCRED_RST)) u_ws (
        .mclk(mclk),
        .resetn(resetn),
        .s_valid(wo_valid),
        .s_ready(wo_ready),
        .s_data(wo_data),
        .s_side(1'b0),
        .s_last(wo_last),
        .s_pending(wo_pending),
        .m_tvalid(ws_tvalid_i),
        .m_tready(ws_tready),
        .m_tdata(ws_tdata_i),
        .m_tside(),
        .m_tlast(ws_tlast_i),
        .m_twakeup(ws_twakeup_i),
        .m_credit(ws_credit),
        .credits()
    );

    // Stitched build keeps this link internal: ports tie off at zero
    assign ws_tvalid = STITCHED ? 1'b0 : ws_tvalid_i;
    assign ws_tdata = STITCHED ? '0 : ws_tdata_i;
    assign ws_tlast = STITCHED ? 1'b0 : ws_tlast_i;
    assign ws_twakeup = STITCHED ? 1'b0 : ws_twakeup_i;

    // Inbound: sender holds credits, so this side never stalls
    assign xr_tready = 1'b1;

    // Capture each beat with keep and source tag, return one credit per beat
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            xi_valid <= 1'b0;
            xi_data <= '0;
            xi_keep <= '0;
            xi_src <= '0;
            xi_last <= 1'b0;
            xr_credit <= 1'b0;
        end else begin
            xi_valid <= xr_tvalid && xr_tready;
            xr_credit <= xr_tvalid && xr_tready;
            if (xr_tvalid && xr_tready) begin
                xi_data <= xr_tdata;
                xi_keep <= xr_tkeep;
                xi_src <= xr_tsrc;
                xi_last <= xr_tlast;
            end
        end
    end

    // Wake arrives from the link pin, so it is synchronised before use
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            xr_wake_s1 <= 1'b0;
            xr_wake_s2 <= 1'b0;
        end else begin
            xr_wake_s1 <= xr_twakeup;
            xr_wake_s2 <= xr_wake_s1;
        end
    end
    assign xi_awake = xr_wake_s2;
endmodule

// File: dxw_pkg.sv
// What this block does
// - Outbound messages to the translation service go as stream beats, moving only when valid and ready are both high.
// - Inbound messages from the translation service arrive with valid, data, keep and last, and this block drives ready.
// - Every translation-service link is credit based, so a sender issues beats only when the receiver can take them.
// - Each sender raises its wake line while a message is arriving or about to arrive; only valid and ready move beats.
// - The outbound translation-service link carries a destination tag that picks the receiving service block.
// - The outbound translation-service link carries a byte keep marking the bytes of each beat to transfer.
// - The inbound translation-service link delivers a source tag naming the service block that sent it.
// - Messages to the wake request block go over a credited stream link with 16-bit data and the valid/ready handshake.
// - The wake output toward the wake request block is registered and high while a message arrives or is about to.
// - In a stitched build the wake request link and its wake output stay internal and are not top-level ports; here the ws_ ports remain and are tied off at zero.
package dxw_pkg;
    localparam int DXW_XDATA_W = 64;
    localparam int DXW_XKEEP_W = DXW_XDATA_W / 8;
    localparam int DXW_XTAG_W = 4;
    localparam int DXW_WDATA_W = 16;
    localparam int DXW_CRED_W = 4;
    localparam logic [DXW_CRED_W-1:0] DXW_XCRED_RST = 4'h4;
    localparam logic [DXW_CRED_W-1:0] DXW_WCRED_RST = 4'h4;
endpackage

// File: dxw_tx_port.sv
`timescale 1ns/1ns
// One credited outbound stream sender with a registered wake line
module dxw_tx_port #(
    parameter int DW = 16,
    parameter int SW = 1,
    parameter logic [dxw_pkg::DXW_CRED_W-1:0] CRED_RST = '0
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic s_valid,
    output logic s_ready,
    input wire logic [DW-1:0] s_data,
    input wire logic [SW-1:0] s_side,
    input wire logic s_last,
    input wire logic s_pending,
    output logic m_tvalid,
    input wire logic m_tready,
    output logic [DW-1:0] m_tdata,
    output logic [SW-1:0] m_tside,
    output logic m_tlast,
    output logic m_twakeup,
    input wire logic m_credit,
    output logic [dxw_pkg::DXW_CRED_W-1:0] credits
);
    import dxw_pkg::*;

    logic full;
    logic in_msg;
    logic fire;
    logic load;

    assign fire = m_tvalid && m_tready;
    // Skid-free single stage: refill when empty or draining, but only on credit
    assign s_ready = (!full || fire) && (credits != '0);
    assign load = s_valid && s_ready;

    // Beat register
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            full <= 1'b0;
            m_tdata <= '0;
            m_tside <= '0;
            m_tlast <= 1'b0;
        end else begin
            if (load) begin
                full <= 1'b1;
                m_tdata <= s_data;
                m_tside <= s_side;
                m_tlast <= s_last;
            end else if (fire) begin
                full <= 1'b0;
            end
        end
    end
    assign m_tvalid = full;

    // Credit taken when a beat is loaded, so valid never rises without one
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            credits <= CRED_RST;
        end else begin
            credits <= credits - {{(DXW_CRED_W-1){1'b0}}, load} + {{(DXW_CRED_W-1){1'b0}}, m_credit};
        end
    end

    // Track open message between first load and last accepted beat
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            in_msg <= 1'b0;
        end else if (load && !s_last) begin
            in_msg <= 1'b1;
        end else if (fire && m_tlast) begin
            in_msg <= 1'b0;
        end
    end

    // Wake leads the first beat by a cycle via s_pending, trails the last
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            m_twakeup <= 1'b0;
        end else begin
            m_twakeup <= s_pending || s_valid || full || in_msg;
        end
    end
endmodule

// File: dxw_checker.sv
`timescale 1ns/1ns
// Port checks on the outbound, inbound and wake request links
module dxw_checker (
    input wire logic mclk, resetn, xo_valid, xo_ready, xo_pending, xs_tvalid, xs_tready,
    input wire logic xs_twakeup, xr_tvalid, xr_tready, xr_credit, xr_twakeup, xi_awake,
    input wire logic ws_tvalid, ws_tready, ws_twakeup,
    input wire logic [dxw_pkg::DXW_XTAG_W-1:0] xo_dest, xs_tdest
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    property p_hold; xs_tvalid && !xs_tready |=> xs_tvalid && $stable(xs_tdest); endproperty
    a_hold: assert property (p_hold) else $error("stalled beat lost");
    property p_dest; xo_valid && xo_ready |=> xs_tvalid && xs_tdest == $past(xo_dest); endproperty
    a_dest: assert property (p_dest) else $error("beat not staged");
    property p_wake; xs_tvalid |-> xs_twakeup; endproperty
    a_wake: assert property (p_wake) else $error("beat without wake");
    property p_pend; xo_pending |=> xs_twakeup; endproperty
    a_pend: assert property (p_pend) else $error("no early wake");
    property p_cred; xr_tvalid && xr_tready |=> xr_credit; endproperty
    a_cred: assert property (p_cred) else $error("no credit back");
    property p_awake; $rose(xr_twakeup) |-> ##2 xi_awake; endproperty
    a_awake: assert property (p_awake) else $error("wake not passed");
    property p_whold; ws_tvalid && !ws_tready |=> ws_tvalid; endproperty
    a_whold: assert property (p_whold) else $error("wake beat lost");
    property p_wwake; ws_tvalid |-> ws_twakeup; endproperty
    a_wwake: assert property (p_wwake) else $error("wake beat unflagged");
endmodule
bind dxw_ports dxw_checker chk_i (.*);

// File: dxw_far_model.sv
`timescale 1ns/1ns
// Far receiver: stalls each cycle it returns a credit, one credit back per beat
module dxw_far_model (
    input wire logic mclk, resetn, tvalid, hold,
    output logic tready, credit,
    output logic [7:0] beats
);
    logic [3:0] owed;
    wire ret = !hold && (owed != 4'h0 || (tvalid && tready));
    // Slow on purpose, so staged beats must wait
    assign tready = !credit;
    // Held credits stay owed, so the sender has to run dry
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            owed <= 4'h0;
            credit <= 1'b0;
            beats <= 8'h0;
        end else begin
            credit <= ret;
            owed <= owed + 4'(tvalid && tready) - 4'(ret);
            beats <= beats + 8'(tvalid && tready);
        end
    end
endmodule

// File: tb_top.sv
`timescale 1ns/1ns
module tb_top;
    logic mclk = 1'b0, resetn = 1'b0, xo_valid = 1'b0, xo_last = 1'b0, xo_pending = 1'b0;
    logic xr_tvalid = 1'b0, xr_tlast = 1'b0, xr_twakeup = 1'b0, x_hold = 1'b0, wo_valid = 1'b0;
    logic wo_last = 1'b0, wo_pending = 1'b0, xo_ready, xs_tvalid, xs_tready, xs_tlast, xs_twakeup;
    logic xs_credit, xr_tready, xr_credit, xi_valid, xi_last, xi_awake, wo_ready, ws_tvalid;
    logic ws_tready, ws_tlast, ws_twakeup, ws_credit;
    logic [63:0] xo_data = '0, xr_tdata = '0, xs_tdata, xi_data;
    logic [7:0] xo_keep = '0, xr_tkeep = '0, xs_tkeep, xi_keep, x_beats, w_beats;
    logic [3:0] xo_dest = '0, xr_tsrc = '0, xs_tdest, xi_src;
    logic [15:0] wo_data = '0, ws_tdata;
    logic st_tvalid, st_tlast, st_twakeup;
    logic [15:0] st_tdata;
    int errors = 0, n_tests = 0;
    // 50 ns period
    always #25 mclk = ~mclk;
    dxw_ports dut (.*);
    // Stitched build: the wake request outputs must stay at zero
    dxw_ports #(.STITCHED(1'b1)) dut_st (.*, .xo_ready(), .xs_tvalid(), .xs_tdata(), .xs_tkeep(),
        .xs_tdest(), .xs_tlast(), .xs_twakeup(), .xr_tready(), .xr_credit(), .xi_valid(),
        .xi_data(), .xi_keep(), .xi_src(), .xi_last(), .xi_awake(), .wo_ready(),
        .ws_tvalid(st_tvalid), .ws_tdata(st_tdata), .ws_tlast(st_tlast), .ws_twakeup(st_twakeup));
    // Receivers for the service link and the wake request link
    dxw_far_model far_x (.mclk(mclk), .resetn(resetn), .tvalid(xs_tvalid), .hold(x_hold),
        .tready(xs_tready), .credit(xs_credit), .beats(x_beats));
    dxw_far_model far_w (.mclk(mclk), .resetn(resetn), .tvalid(ws_tvalid), .hold(1'b0),
        .tready(ws_tready), .credit(ws_credit), .beats(w_beats));
    task automatic chk(input logic [79:0] got, input logic [79:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %0t %h %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Seven beats back to back; credits held until four have gone
    task automatic s_out;
        x_hold <= 1'b1;
        xo_valid <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            xo_dest <= 4'(i);
            xo_keep <= 8'(i);
            xo_data <= 64'h1111111111111111 * 64'(i);
            xo_last <= (i == 6);
            do @(posedge mclk); while (xo_ready !== 1'b1);
            if (i == 3) begin
                repeat (4) @(posedge mclk);
                chk({xo_ready, x_beats}, 80'h004);
                chk({xs_tlast, xs_tkeep, xs_tdest, xs_tdata}, {13'h033, 64'h3333333333333333});
                x_hold <= 1'b0;
            end
        end
        xo_valid <= 1'b0;
        repeat (8) @(posedge mclk);
        chk({xs_twakeup, x_beats}, 80'h007);
        chk({xs_tlast, xs_tkeep, xs_tdest, xs_tdata}, {13'h1066, 64'h6666666666666666});
    endtask
    // Inbound beat, wake request beat and early wakes on one edge
    task automatic s_in;
        xr_tdata <= 64'h5a;
        xr_tkeep <= 8'h0f;
        xr_tsrc <= 4'h9;
        xr_tlast <= 1'b1;
        wo_last <= 1'b1;
        xr_tvalid <= 1'b1;
        xr_twakeup <= 1'b1;
        xo_pending <= 1'b1;
        wo_data <= 16'h3c1;
        wo_valid <= 1'b1;
        @(posedge mclk);
        chk({wo_ready, xr_tready}, 80'h3);
        xr_tvalid <= 1'b0;
        wo_valid <= 1'b0;
        xr_tdata <= ~64'h5a;
        @(negedge mclk);
        chk({xi_last, xi_valid, xi_src, xi_keep, xi_data}, {2'h0, 14'h390f, 64'h5a});
        chk({xr_credit, xs_twakeup, ws_twakeup}, 80'h7);
        chk({st_tvalid, st_tlast, st_twakeup, st_tdata}, 80'h0);
        repeat (3) @(posedge mclk);
        chk({xi_awake, w_beats}, 80'h101);
        chk({ws_tlast, ws_twakeup, ws_tdata}, 80'h203c1);
        xr_twakeup <= 1'b0;
        xo_pending <= 1'b0;
    endtask
    // Hang guard, several times the expected run
    initial begin
        repeat (600) @(posedge mclk);
        errors++;
        stop_test();
    end
    initial begin
        repeat (20) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        s_out();
        s_in();
        stop_test();
    end
endmodule
